// >>> core/iatr_pkg.sv
// Package: register map, field layout, reset values and shared types
package iatr_pkg;

  // Byte offsets of the threshold words (each word spans four bytes)
  localparam logic [7:0]  IATR_UPPER_OFS    = 8'h24;
  localparam logic [7:0]  IATR_LOWER_OFS    = 8'h28;
  // Own registers: alarm status, interrupt mask, conversion injection
  localparam logic [7:0]  IATR_STATUS_OFS   = 8'h2C;
  localparam logic [7:0]  IATR_MASK_OFS     = 8'h30;
  localparam logic [7:0]  IATR_SAMPLE_OFS   = 8'h34;

  // Field positions
  localparam int          IATR_HYST_LSB     = 24;
  localparam int          IATR_HYST_USE_LSB = 2;
  localparam int          IATR_ACT_HI_BIT   = 10;
  localparam int          IATR_ACT_LO_BIT   = 11;
  localparam int          IATR_TRP_HI_BIT   = 4;
  localparam int          IATR_TRP_LO_BIT   = 5;
  localparam int          IATR_OVW_BIT      = 0;

  // Reset values
  localparam logic [15:0] IATR_UPPER_RST    = 16'hFFFF;
  localparam logic [15:0] IATR_LOWER_RST    = 16'h0000;
  localparam logic [7:0]  IATR_HYST_RST     = 8'h00;
  localparam logic [1:0]  IATR_MASK_RST     = 2'b00;

  // Alarm event pair: bit 0 high side, bit 1 low side
  typedef struct packed {
    logic lowSide;
    logic highSide;
  } iatr_pair_t;

  // APB request bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } iatr_apb_req_t;

endpackage

// >>> core/iatr_reset_sync.sv
// Reset synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ps
module iatr_reset_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      rstSync_b
);
  logic stage1_q;
  logic stage2_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end

  assign rstSync_b = stage2_q;
endmodule // iatr_reset_sync

// >>> core/iatr_compare.sv
// Threshold comparator with hysteresis for one side of the input alarm
`timescale 1ns/1ps
module iatr_compare #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstSync_b,
  input  wire logic         sampleValid,
  input  wire logic [W-1:0] sample,
  input  wire logic [W-1:0] threshold,
  input  wire logic [5:0]   hysteresis,
  input  wire logic         isHighSide,
  output logic              active
);
  logic          active_q;
  logic [W:0]    releaseLvl;
  logic          trip;
  logic          clear;

  // Release point moves back by the hysteresis; one extra bit for headroom
  always_comb begin
    releaseLvl = '0;
    trip       = 1'b0;
    clear      = 1'b0;
    if (isHighSide) begin
      releaseLvl = {1'b0, threshold} - {{(W-5){1'b0}}, hysteresis};
      trip       = sample > threshold;
      // A borrow means no release point exists, so the alarm stays set
      clear      = !releaseLvl[W] && ({1'b0, sample} < releaseLvl);
    end else begin
      releaseLvl = {1'b0, threshold} + {{(W-5){1'b0}}, hysteresis};
      trip       = sample < threshold;
      clear      = {1'b0, sample} > releaseLvl;
    end
  end

  // Live flag only updates on a fresh conversion result
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      active_q <= 1'b0;
    end else if (sampleValid) begin
      if (trip) begin
        active_q <= 1'b1;
      end else if (clear) begin
        active_q <= 1'b0;
      end
    end
  end

  assign active = active_q;
endmodule // iatr_compare

// >>> core/iatr_regs.sv
// Input alarm threshold register bank with APB slave and alarm status
`timescale 1ns/1ps
// How it works
// R1: Upper-limit word at 24h..27h, least significant byte lowest.
// R2: Upper threshold bits 15:0, read/write, resets to FFFFh.
// R3: Hysteresis bits 31:24, read/write, reset 00h; upper six bits used.
// R4: Host writes zeros into the two low hysteresis bits.
// R5: Upper-limit bits 23:16 are reserved and read zero.
// R6: Lower-limit word at 28h..2Bh, least significant byte lowest.
// R7: Lower threshold bits 15:0, read/write, resets to 0000h.
// R8: Lower-limit bits 31:16 are reserved and read zero.
// R9: Separate live high and low alarm flags reflect present conditions.
// R10: Overall alarm bit is OR of all tripped flags.
// R11: Alarms trip past thresholds, clear after moving back by hysteresis.
module iatr_regs (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sampleValid,
  input  wire logic [15:0]          sample,
  output iatr_pkg::iatr_pair_t      liveAlarm,
  output logic                      overallAlarm,
  output logic                      irq
);
  import iatr_pkg::*;

  logic          rstSync_b;
  iatr_apb_req_t req;
  logic          wrEn;
  logic          rdEn;
  logic          hitMapped;
  logic [15:0]   upperThr_q;
  logic [7:0]    hyst_q;
  logic [15:0]   lowerThr_q;
  logic [1:0]    mask_q;
  iatr_pair_t    tripped_q;
  iatr_pair_t    tripped_d;
  iatr_pair_t    live;
  logic          liveHigh;
  logic          liveLow;
  logic          injValid_q;
  logic [15:0]   injSample_q;
  logic          cmpValid;
  logic [15:0]   cmpSample;
  logic [31:0]   rdWord;
  logic [31:0]   statusWord;

  iatr_reset_sync uRst (
    .clk       (clk),
    .rst_b     (rst_b),
    .rstSync_b (rstSync_b)
  );

  // Bundle the bus signals for decode
  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata, strb: pstrb};

  // Zero wait states; effect happens at the access-phase edge
  assign pready = 1'b1;
  assign wrEn   = req.sel && req.enable && req.write;
  assign rdEn   = req.sel && req.enable && !req.write;
  assign hitMapped = (req.addr == IATR_UPPER_OFS) ||
                     (req.addr == IATR_LOWER_OFS) ||
                     (req.addr == IATR_STATUS_OFS) ||
                     (req.addr == IATR_MASK_OFS) ||
                     (req.addr == IATR_SAMPLE_OFS);
  // Unmapped or misaligned word addresses answer with an error
  assign pslverr = req.sel && req.enable && !hitMapped;

  // Upper-limit word; strobe lane n is byte address base+n
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      upperThr_q <= IATR_UPPER_RST; // R2
      hyst_q     <= IATR_HYST_RST; // R3
    end else if (wrEn && req.addr == IATR_UPPER_OFS) begin
      if (req.strb[0]) upperThr_q[7:0]  <= req.wdata[7:0]; // R1
      if (req.strb[1]) upperThr_q[15:8] <= req.wdata[15:8]; // R1
      // Low two bits kept as written; host keeps them zero
      if (req.strb[3]) hyst_q <= req.wdata[31:24]; // R3
    end
  end

  // Lower-limit word; upper half has no storage
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lowerThr_q <= IATR_LOWER_RST; // R7
    end else if (wrEn && req.addr == IATR_LOWER_OFS) begin
      if (req.strb[0]) lowerThr_q[7:0]  <= req.wdata[7:0]; // R6
      if (req.strb[1]) lowerThr_q[15:8] <= req.wdata[15:8]; // R6
    end
  end

  // Interrupt mask, same layout as the tripped bits
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      mask_q <= IATR_MASK_RST;
    end else if (wrEn && req.addr == IATR_MASK_OFS && req.strb[0]) begin
      mask_q <= req.wdata[IATR_TRP_LO_BIT:IATR_TRP_HI_BIT];
    end
  end

  // Conversion results arrive on the port or by software injection
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      injValid_q  <= 1'b0;
      injSample_q <= 16'h0000;
    end else begin
      injValid_q <= wrEn && req.addr == IATR_SAMPLE_OFS;
      if (wrEn && req.addr == IATR_SAMPLE_OFS) begin
        injSample_q <= req.wdata[15:0];
      end
    end
  end

  assign cmpValid  = sampleValid || injValid_q;
  assign cmpSample = injValid_q ? injSample_q : sample;

  // Only the six upper hysteresis bits carry the amount
  iatr_compare #(.W(16)) uHigh (
    .clk         (clk),
    .rstSync_b   (rstSync_b),
    .sampleValid (cmpValid),
    .sample      (cmpSample),
    .threshold   (upperThr_q),
    .hysteresis  (hyst_q[7:IATR_HYST_USE_LSB]), // R4
    .isHighSide  (1'b1),
    .active      (liveHigh) // R11
  );

  iatr_compare #(.W(16)) uLow (
    .clk         (clk),
    .rstSync_b   (rstSync_b),
    .sampleValid (cmpValid),
    .sample      (cmpSample),
    .threshold   (lowerThr_q),
    .hysteresis  (hyst_q[7:IATR_HYST_USE_LSB]),
    .isHighSide  (1'b0),
    .active      (liveLow) // R11
  );

  // One driver for the whole pair keeps the live flags single-sourced
  assign live = '{lowSide: liveLow, highSide: liveHigh};

  // Sticky tripped flags: a live alarm wins over the read that clears
  always_comb begin
    tripped_d = tripped_q;
    if (rdEn && req.addr == IATR_STATUS_OFS) begin
      tripped_d = '0;
    end
    tripped_d = tripped_d | live;
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      tripped_q <= '0;
    end else begin
      tripped_q <= tripped_d;
    end
  end

  assign liveAlarm    = live; // R9
  assign overallAlarm = |tripped_q; // R10
  assign irq          = |(tripped_q & mask_q);

  // Status word: live flags, tripped flags and their OR
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[IATR_ACT_HI_BIT] = live.highSide; // R9
    statusWord[IATR_ACT_LO_BIT] = live.lowSide; // R9
    statusWord[IATR_TRP_HI_BIT] = tripped_q.highSide;
    statusWord[IATR_TRP_LO_BIT] = tripped_q.lowSide;
    statusWord[IATR_OVW_BIT]    = |tripped_q; // R10
  end

  // Read mux; reserved fields return zero
  always_comb begin
    rdWord = 32'h0000_0000;
    case (req.addr)
      IATR_UPPER_OFS:  rdWord = {hyst_q, 8'h00, upperThr_q}; // R5
      IATR_LOWER_OFS:  rdWord = {16'h0000, lowerThr_q}; // R8
      IATR_STATUS_OFS: rdWord = statusWord;
      IATR_MASK_OFS:   rdWord = {26'h0, mask_q, 4'h0};
      default:         rdWord = 32'h0000_0000;
    endcase
  end

  // Read data from a flop, loaded in the setup phase
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prdata <= 32'h0000_0000;
    end else if (req.sel && !req.enable && !req.write) begin
      prdata <= rdWord;
    end
  end

  // Checks
  property p_upper_rst;
    @(posedge clk) $rose(rstSync_b) |-> upperThr_q == 16'hFFFF;
  endproperty
  a_upper_rst: assert property (p_upper_rst) else $error("upper reset"); // R2

  property p_lower_rst;
    @(posedge clk) $rose(rstSync_b) |-> lowerThr_q == 16'h0000;
  endproperty
  a_lower_rst: assert property (p_lower_rst) else $error("lower reset"); // R7

  property p_upper_wr;
    @(posedge clk) disable iff (!rstSync_b)
      wrEn && req.addr == 8'h24 && req.strb == 4'hF |=>
      upperThr_q == $past(req.wdata[15:0]) &&
      hyst_q == $past(req.wdata[31:24]);
  endproperty
  a_upper_wr: assert property (p_upper_wr) else $error("upper write"); // R1

  property p_lower_wr;
    @(posedge clk) disable iff (!rstSync_b)
      wrEn && req.addr == 8'h28 && req.strb[1:0] == 2'b11 |=>
      lowerThr_q == $past(req.wdata[15:0]);
  endproperty
  a_lower_wr: assert property (p_lower_wr) else $error("lower write"); // R6

  property p_res_upper;
    @(posedge clk) disable iff (!rstSync_b)
      rdEn && req.addr == 8'h24 |-> prdata[23:16] == 8'h00;
  endproperty
  a_res_upper: assert property (p_res_upper) else $error("resv hi"); // R5

  property p_res_lower;
    @(posedge clk) disable iff (!rstSync_b)
      rdEn && req.addr == 8'h28 |-> prdata[31:16] == 16'h0000;
  endproperty
  a_res_lower: assert property (p_res_lower) else $error("resv lo"); // R8

  property p_hyst_rd;
    @(posedge clk) disable iff (!rstSync_b)
      rdEn && req.addr == 8'h24 |-> prdata[31:24] == hyst_q;
  endproperty
  a_hyst_rd: assert property (p_hyst_rd) else $error("hyst read"); // R3

  property p_trip_high;
    @(posedge clk) disable iff (!rstSync_b)
      cmpValid && cmpSample > upperThr_q |=> live.highSide ##1 tripped_q[0];
  endproperty
  a_trip_high: assert property (p_trip_high) else $error("high trip"); // R11

  property p_live_stat;
    @(posedge clk) disable iff (!rstSync_b)
      rdEn && req.addr == 8'h2C && $stable(live) && $past(req.sel) |->
      prdata[11:10] == {live.lowSide, live.highSide};
  endproperty
  a_live_stat: assert property (p_live_stat) else $error("live flag"); // R9

  property p_ovw;
    @(posedge clk) disable iff (!rstSync_b)
      (|live) |=> overallAlarm;
  endproperty
  a_ovw: assert property (p_ovw) else $error("overall alarm"); // R10

  property p_hyst_rst;
    @(posedge clk) $rose(rstSync_b) |-> hyst_q == IATR_HYST_RST;
  endproperty
  a_hyst_rst: assert property (p_hyst_rst) else $error("hyst reset"); // R3

  // Thresholds move only on a write to their own word
  property p_hold_upper;
    @(posedge clk) disable iff (!rstSync_b)
      !(wrEn && req.addr == IATR_UPPER_OFS) |=>
      $stable(upperThr_q) && $stable(hyst_q);
  endproperty
  a_hold_upper: assert property (p_hold_upper) else $error("hold hi"); // R2

  property p_upper_resv;
    @(posedge clk) disable iff (!rstSync_b)
      wrEn && req.addr == IATR_UPPER_OFS && req.strb == 4'h4 |=>
      $stable(upperThr_q) && $stable(hyst_q);
  endproperty
  a_upper_resv: assert property (p_upper_resv) else $error("rsv wr hi"); // R5

  property p_lower_resv;
    @(posedge clk) disable iff (!rstSync_b)
      wrEn && req.addr == IATR_LOWER_OFS && req.strb[1:0] == 2'b00 |=>
      $stable(lowerThr_q);
  endproperty
  a_lower_resv: assert property (p_lower_resv) else $error("rsv wr lo"); // R8

  property p_trip_low;
    @(posedge clk) disable iff (!rstSync_b)
      cmpValid && cmpSample < lowerThr_q |=>
      live.lowSide ##1 tripped_q.lowSide;
  endproperty
  a_trip_low: assert property (p_trip_low) else $error("low trip"); // R11

  property p_clr_high;
    @(posedge clk) disable iff (!rstSync_b)
      cmpValid && ({1'b0, cmpSample} + {11'h000, hyst_q[7:2]} <
                   {1'b0, upperThr_q}) |=> !live.highSide;
  endproperty
  a_clr_high: assert property (p_clr_high) else $error("high clear"); // R11

  property p_clr_low;
    @(posedge clk) disable iff (!rstSync_b)
      cmpValid && ({1'b0, cmpSample} >
                   {1'b0, lowerThr_q} + {11'h000, hyst_q[7:2]}) |=>
      !live.lowSide;
  endproperty
  a_clr_low: assert property (p_clr_low) else $error("low clear"); // R11

  // Live flags move only on a fresh conversion result
  property p_live_hold;
    @(posedge clk) disable iff (!rstSync_b) !cmpValid |=> $stable(live);
  endproperty
  a_live_hold: assert property (p_live_hold) else $error("live held"); // R9

  // Status read clears the sticky flags unless an alarm is live
  property p_rd_clear;
    @(posedge clk) disable iff (!rstSync_b)
      rdEn && req.addr == IATR_STATUS_OFS && !(|live) |=> !(|tripped_q);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read clear"); // R10

  property p_set_wins;
    @(posedge clk) disable iff (!rstSync_b)
      rdEn && req.addr == IATR_STATUS_OFS && live.highSide |=>
      tripped_q.highSide;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set wins"); // R10

  property p_stat_ovw;
    @(posedge clk) disable iff (!rstSync_b)
      req.sel && !req.enable && !req.write &&
      req.addr == IATR_STATUS_OFS |=>
      prdata[IATR_OVW_BIT] == $past(|tripped_q);
  endproperty
  a_stat_ovw: assert property (p_stat_ovw) else $error("status or"); // R10

  property p_misalign;
    @(posedge clk) disable iff (!rstSync_b)
      req.sel && req.enable && req.addr[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned"); // R1

  c_high: cover property (@(posedge clk) live.highSide);
  c_low:  cover property (@(posedge clk) live.lowSide);
  c_irq:  cover property (@(posedge clk) irq);
  c_clr:  cover property (@(posedge clk) $fell(live.highSide));
  c_lclr: cover property (@(posedge clk) $fell(live.lowSide));
endmodule // iatr_regs

// >>> verification/iatr_host.sv
// Host controller model: APB master for the threshold registers
`timescale 1ns/1ps
module iatr_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  output logic             stuck
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    stuck = 1'b0;
  end

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    // Low two hysteresis bits always go out as zero
    pwdata <= (a == iatr_pkg::IATR_UPPER_OFS) ?
              (d & 32'hFCFF_FFFF) : d;
    pstrb <= w ? s : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    stuck = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data toggles so a stale value is never trusted
    pwdata <= ~pwdata;
  endtask
endmodule // iatr_host

// >>> verification/iatr_regs_tb.sv
// Testbench for the input alarm threshold register bank
`timescale 1ns/1ps
module iatr_regs_tb;
  import iatr_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sampleValid;
  logic [15:0] sample;
  iatr_pair_t  liveAlarm;
  logic        overallAlarm;
  logic        irq;
  logic        stuck;
  logic [32:0] expQ[$];
  logic [31:0] model;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          num_checks = 0;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  iatr_regs uut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid),
    .sample(sample), .liveAlarm(liveAlarm),
    .overallAlarm(overallAlarm), .irq(irq));

  iatr_host u_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .stuck(stuck));

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Note the expected {error, read data}, then run the transfer
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] dd, input logic [3:0] s,
                    input logic [32:0] x);
    expQ.push_back(x);
    u_host.xfer(w, a, dd, s);
    if (stuck) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // Conversion pulse on the port; settle, then compare live flags
  task automatic samp(input logic [15:0] v, input logic [1:0] e);
    int n;
    @(posedge clk);
    sampleValid <= 1'b1;
    sample <= v;
    @(posedge clk);
    sampleValid <= 1'b0;
    sample <= ~v;
    n = 0;
    while (liveAlarm !== e && n < 8) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    check({31'h0, liveAlarm}, {31'h0, e});
  endtask

  // Completed transfers are matched to the oldest note; writes read 0
  always @(posedge clk)
    if (psel && penable && pready && expQ.size() > 0)
      check({pslverr, pwrite ? 32'h0 : prdata}, expQ.pop_front());

  // Hang guard
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    sampleValid = 1'b0;
    sample = 16'h0000;
    d = $urandom(23);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    xf(0, IATR_UPPER_OFS, 0, 0, {1'b0, 32'h0000_FFFF});
    xf(0, IATR_LOWER_OFS, 0, 0, 33'h0);
    xf(0, IATR_STATUS_OFS, 0, 0, 33'h0);
    xf(1, 8'h40, 32'hFFFF_FFFF, 4'hF, {1'b1, 32'h0});
    xf(0, 8'h40, 0, 0, {1'b1, 32'h0});
    xf(0, 8'h25, 0, 0, {1'b1, 32'h0});
    $display("test reset done");
    // Each byte lane alone: byte n sits at offset plus n
    for (int r = 0; r < 2; r++) begin
      model = r ? 32'h0 : 32'h0000_FFFF;
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        xf(1, r ? IATR_LOWER_OFS : IATR_UPPER_OFS, d, 4'h1 << i, 33'h0);
        model[8*i +: 8] = d[8*i +: 8];
        model = model & (r ? 32'h0000_FFFF : 32'hFC00_FFFF);
        xf(0, r ? IATR_LOWER_OFS : IATR_UPPER_OFS, 0, 0,
           {1'b0, model});
      end
    end
    xf(1, IATR_LOWER_OFS, 32'hFFFF_FFFF, 4'hF, 33'h0);
    xf(0, IATR_LOWER_OFS, 0, 0, {1'b0, 32'h0000_FFFF});
    $display("test lanes done");
    // Upper 1000h with amount 4, lower 0100h
    xf(1, IATR_UPPER_OFS, 32'h1000_1000, 4'hF, 33'h0);
    xf(1, IATR_LOWER_OFS, 32'h0000_0100, 4'hF, 33'h0);
    samp(16'h1000, 2'b00);
    samp(16'h1001, 2'b01);
    xf(1, IATR_MASK_OFS, 32'h0000_0010, 4'hF, 33'h0);
    xf(0, IATR_MASK_OFS, 0, 0, {1'b0, 32'h0000_0010});
    repeat (2) @(posedge clk);
    check({32'h0, irq}, 33'h1);
    check({32'h0, overallAlarm}, 33'h1);
    xf(0, IATR_STATUS_OFS, 0, 0, {1'b0, 32'h0000_0411});
    samp(16'h0FFC, 2'b01);
    samp(16'h0FFB, 2'b00);
    xf(0, IATR_STATUS_OFS, 0, 0, {1'b0, 32'h0000_0011});
    xf(0, IATR_STATUS_OFS, 0, 0, 33'h0);
    check({32'h0, irq}, 33'h0);
    check({32'h0, overallAlarm}, 33'h0);
    $display("test high alarm done");
    // Conversion injected through the register path
    xf(1, IATR_SAMPLE_OFS, 32'h0000_00FF, 4'hF, 33'h0);
    repeat (3) @(posedge clk);
    check({31'h0, liveAlarm}, {31'h0, 2'b10});
    xf(0, IATR_STATUS_OFS, 0, 0, {1'b0, 32'h0000_0821});
    check({32'h0, irq}, 33'h0);
    samp(16'h0104, 2'b10);
    samp(16'h0105, 2'b00);
    $display("test low alarm done");
    end_sim();
  end
endmodule // iatr_regs_tb
